// file: common/usb_ep_defines.svh
// Register offsets, field positions, reset values and mode codes
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH

`define OFS_DEV_ADDR 8'h40
`define OFS_CTRL_CNT 8'h44
`define OFS_CTRL_MODE 8'h48
`define OFS_EP1_CNT 8'h4c
`define OFS_DATA_EP_ONE_MODE 8'h50
`define OFS_EP2_CNT 8'h54
`define OFS_DATA_EP_TWO_MODE 8'h58
`define OFS_FIFO_WIN 8'h80
`define IDX_CTRL_CNT 8'h11
`define IDX_CTRL_MODE 8'h12
`define IDX_EP1_CNT 8'h13
`define IDX_DATA_EP_ONE_MODE 8'h14
`define IDX_EP2_CNT 8'h15
`define IDX_DATA_EP_TWO_MODE 8'h16
`define IDX_DEV_ADDR 8'h10
`define FIFO_CTRL_BASE 8'hf8
`define FIFO_EP1_BASE 8'hf0
`define FIFO_EP2_BASE 8'he8
`define FIFO_LO_BASE 8'he8
`define BIT_SETUP 7
`define BIT_STALL 7
`define BIT_IN 6
`define BIT_OUT 5
`define BIT_ACKED 4
`define BIT_TOGGLE 7
`define BIT_VALID 6
`define BIT_ADDR_EN 7
`define REG_RESET 8'h00
`define MODE_NAK_INOUT 4'h1
`define MODE_ACK_OUT_NAK_IN 4'hb
`define MODE_ACK_IN 4'hf
`define MODE_ACK_OUT 4'h9
`define MODE_DISABLE 4'h0
`define CRC_BYTES 4'h2

`endif

// file: common/usb_ep_pkg.sv
// Types for the endpoint register block
package usb_ep_pkg;
  typedef enum logic [1:0] {
    TOK_OUT = 2'b00,
    TOK_IN = 2'b01,
    TOK_SETUP = 2'b10
  } token_t;
  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_ACK = 2'b01,
    HS_NAK = 2'b10,
    HS_STALL = 2'b11
  } handshake_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage : usb_ep_pkg

// file: hw/usb_endpoint_mode_count_regs.sv
// Endpoint mode, counter and FIFO registers of the low-speed USB engine
`timescale 1ns/10ps
`include "usb_ep_defines.svh"
// Notes on behaviour
// - Control endpoint payload sits in eight bytes at 0xf8 to 0xff.
// - First data endpoint FIFO at 0xf0-0xf7, second at 0xe8-0xef.
// - Engine update of control mode bits 7:0 locks CPU writes until read.
// - An unlocked write to control mode clears flags 7:4 regardless of data.
// - Setup flag forced high from setup data until the handshake is sent (hs_sent); CPU cannot clear.
// - While setup flag is high, CPU writes to control FIFO are blocked.
// - In-seen flag sets after a valid IN transaction to control endpoint.
// - Out-seen flag sets after a valid OUT transaction to control endpoint.
// - Each endpoint's acked flag sets when its transaction ends with ACK.
// - Mode 0001 NAKs IN and OUT and ACKs SETUP.
// - Mode 1011 returns to 0001 after ACKing an OUT.
// - Data endpoint mode registers have no write lock.
// - Data endpoint modes behave as control modes, including auto changes.
// - Stall bit stalls OUT in ack-OUT mode and IN in ack-IN mode.
// - Counter bit 7 is toggle; firmware sets for IN, hardware loads on OUT/SETUP.
// - Payload-ok cleared on CRC, stuff or PID error for OUT/SETUP.
// - Invalid data still raises the endpoint event with payload-ok zero.
// - Hardware writes received bytes plus two after OUT/SETUP.
// - OUT/SETUP update locks control counter until the CPU reads it.
// - Engine answers traffic only at enabled matching address.
module usb_endpoint_mode_count_regs
  import usb_ep_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Engine side, same clock
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic [6:0] tok_addr,
  input wire logic [1:0] tok_ep,
  input wire logic data_start,
  input wire logic rx_done,
  input wire logic rx_ok,
  input wire logic rx_toggle,
  input wire logic [3:0] rx_count,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic hs_sent,
  input wire logic host_ack,
  output logic [1:0] hs_code,
  output logic hs_valid,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_toggle,
  output logic tx_last,
  input wire logic tx_ready,
  output logic [2:0] ep_event
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] fifo_r [0:23];
  logic [7:0] dev_addr_r;
  logic [7:0] cnt_r [0:2];
  logic [7:0] mode_r [0:2];
  logic mode_lock_r;
  logic cnt_lock_r;
  logic [1:0] cur_ep_r;
  token_t cur_tok_r;
  logic active_r;
  logic [3:0] rx_ptr_r;
  logic [3:0] tx_ptr_r;
  logic tx_run_r;
  logic await_ack_r;

  function automatic logic [4:0] fifo_index(input logic [1:0] ep, input logic [2:0] off);
    logic [7:0] base;
    base = (ep == 2'd0) ? `FIFO_CTRL_BASE : (ep == 2'd1) ? `FIFO_EP1_BASE : `FIFO_EP2_BASE;
    fifo_index = 5'(base - `FIFO_LO_BASE) + {2'b00, off};
  endfunction : fifo_index

  function automatic handshake_t mode_answer(input logic [3:0] md, input logic stall,
                                            input token_t tk);
    mode_answer = HS_NONE;
    unique case (md)
      `MODE_NAK_INOUT: mode_answer = (tk == TOK_SETUP) ? HS_ACK : HS_NAK;
      `MODE_ACK_OUT_NAK_IN, `MODE_ACK_OUT:
        mode_answer = (tk == TOK_IN) ? HS_NAK :
                      (stall && tk == TOK_OUT) ? HS_STALL : HS_ACK;
      `MODE_ACK_IN:
        mode_answer = (tk == TOK_IN) ? (stall ? HS_STALL : HS_ACK) : HS_NAK;
      default: mode_answer = HS_NONE;
    endcase
  endfunction : mode_answer

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  wr_state_t wr_state_r;
  logic [7:0] aw_r;
  logic [31:0] w_r;
  logic aw_have_r;
  logic w_have_r;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_addr;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_awready = !aw_have_r && wr_state_r == WR_IDLE;
  assign s_axi_wready = !w_have_r && wr_state_r == WR_IDLE;
  assign wr_go = aw_have_r && w_have_r && wr_state_r == WR_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_r <= 8'h00;
      w_r <= 32'h0;
      wr_state_r <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        wr_state_r <= WR_RESP;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        wr_state_r <= WR_IDLE;
      end
    end
  end

  logic wr_mapped;
  assign wr_mapped = (aw_r[7] && aw_r[6:2] <= 5'd23) || (aw_r >= `OFS_DEV_ADDR && aw_r <= `OFS_DATA_EP_TWO_MODE
                     && aw_r[1:0] == 2'b00);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    if (rd_addr[7]) begin
      rd_val = {24'h0, fifo_r[rd_addr[6:2]]};
      if (rd_addr[6:2] > 5'd23) begin
        rd_hit = 1'b0;
      end
    end else begin
      unique case (rd_addr)
        `OFS_DEV_ADDR: rd_val = {24'h0, dev_addr_r};
        `OFS_CTRL_CNT: rd_val = {24'h0, cnt_r[0]};
        `OFS_CTRL_MODE: rd_val = {24'h0, mode_r[0]};
        `OFS_EP1_CNT: rd_val = {24'h0, cnt_r[1]};
        `OFS_DATA_EP_ONE_MODE: rd_val = {24'h0, mode_r[1]};
        `OFS_EP2_CNT: rd_val = {24'h0, cnt_r[2]};
        `OFS_DATA_EP_TWO_MODE: rd_val = {24'h0, mode_r[2]};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_val : 32'h0;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Engine transaction tracking
  // ----------------------------------------
  logic tok_hit;
  handshake_t answer;
  assign tok_hit = tok_valid && dev_addr_r[`BIT_ADDR_EN]
                   && tok_addr == dev_addr_r[6:0] && tok_ep != 2'd3;
  assign answer = mode_answer(mode_r[tok_ep][3:0], tok_ep != 2'd0 && mode_r[tok_ep][`BIT_STALL],
                              token_t'(tok_kind));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= 1'b0;
      cur_ep_r <= 2'd0;
      cur_tok_r <= TOK_OUT;
      hs_valid <= 1'b0;
      hs_code <= 2'b00;
      await_ack_r <= 1'b0;
    end else begin
      hs_valid <= 1'b0;
      if (tok_hit) begin
        active_r <= 1'b1;
        cur_ep_r <= tok_ep;
        cur_tok_r <= token_t'(tok_kind);
        hs_code <= answer;
        await_ack_r <= tok_kind == TOK_IN && answer == HS_ACK;
        hs_valid <= tok_kind == TOK_IN && answer != HS_ACK && answer != HS_NONE;
        if (answer == HS_NONE) begin
          active_r <= 1'b0;
        end
      end else if (active_r && rx_done) begin
        hs_valid <= rx_ok && hs_code != HS_NONE;
        active_r <= rx_ok;
      end else if (active_r && (hs_sent || (await_ack_r && host_ack))) begin
        active_r <= 1'b0;
        await_ack_r <= 1'b0;
      end
    end
  end

  logic ack_done;
  logic rx_end;
  assign ack_done = active_r && hs_code == HS_ACK
                    && ((cur_tok_r != TOK_IN && hs_sent) || (await_ack_r && host_ack));
  assign rx_end = active_r && rx_done && cur_tok_r != TOK_IN;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_event <= 3'b000;
    end else begin
      ep_event <= 3'b000;
      if (ack_done || (rx_end && !rx_ok)) begin
        ep_event[cur_ep_r] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmit from FIFO
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_run_r <= 1'b0;
      tx_ptr_r <= 4'h0;
    end else if (tok_hit && tok_kind == TOK_IN && answer == HS_ACK) begin
      tx_run_r <= 1'b1;
      tx_ptr_r <= 4'h0;
    end else if (tx_run_r && tx_ready && (tx_last || !tx_valid)) begin
      tx_run_r <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      tx_ptr_r <= tx_ptr_r + 4'h1;
    end
  end

  logic [3:0] tx_len;
  assign tx_len = cnt_r[cur_ep_r][3:0];
  assign tx_valid = tx_run_r && tx_ptr_r < tx_len && tx_len <= 4'h8;
  assign tx_last = tx_run_r && (tx_len == 4'h0 || tx_ptr_r + 4'h1 >= tx_len);
  assign tx_toggle = cnt_r[cur_ep_r][`BIT_TOGGLE];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_byte <= 8'h00;
    end else begin
      tx_byte <= fifo_r[fifo_index(tok_hit ? tok_ep : cur_ep_r,
                 tok_hit ? 3'd0 : tx_ptr_r[2:0] + (tx_valid && tx_ready ? 3'd1 : 3'd0))];
    end
  end

  // ----------------------------------------
  // FIFO writes: engine receive and CPU
  // ----------------------------------------
  logic cpu_wr;
  assign cpu_wr = wr_go && aw_r[7] && aw_r[6:2] <= 5'd23;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ptr_r <= 4'h0;
    end else if (tok_hit) begin
      rx_ptr_r <= 4'h0;
    end else if (active_r && rx_byte_valid && rx_ptr_r < 4'h8) begin
      rx_ptr_r <= rx_ptr_r + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 24; i++) begin
        fifo_r[i] <= 8'h00;
      end
    end else begin
      if (cpu_wr && !(aw_r[6:2] >= 5'd16 && mode_r[0][`BIT_SETUP])) begin
        fifo_r[aw_r[6:2]] <= w_r[7:0];
      end
      if (active_r && rx_byte_valid && rx_ptr_r < 4'h8 && hs_code == HS_ACK) begin
        fifo_r[fifo_index(cur_ep_r, rx_ptr_r[2:0])] <= rx_byte;
      end
    end
  end

  // ----------------------------------------
  // Address, mode and counter registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_addr_r <= `REG_RESET;
    end else if (wr_go && aw_r == `OFS_DEV_ADDR) begin
      dev_addr_r <= w_r[7:0];
    end
  end

  logic setup_data;
  logic mode_upd;
  logic cnt_upd;
  assign setup_data = active_r && cur_tok_r == TOK_SETUP && cur_ep_r == 2'd0 && data_start;
  assign mode_upd = cur_ep_r == 2'd0 && (setup_data || ack_done || (rx_end && rx_ok));
  assign cnt_upd = rx_end && hs_code == HS_ACK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_lock_r <= 1'b0;
    end else if (mode_upd) begin
      mode_lock_r <= 1'b1;
    end else if (rd_go && rd_addr == `OFS_CTRL_MODE) begin
      mode_lock_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_lock_r <= 1'b0;
    end else if (cnt_upd && cur_ep_r == 2'd0) begin
      cnt_lock_r <= 1'b1;
    end else if (rd_go && rd_addr == `OFS_CTRL_CNT) begin
      cnt_lock_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < 3; e++) begin
        mode_r[e] <= `REG_RESET;
      end
    end else begin
      if (wr_go && aw_r == `OFS_CTRL_MODE && !mode_lock_r) begin
        mode_r[0] <= {4'h0, w_r[3:0]};
      end
      if (wr_go && aw_r == `OFS_DATA_EP_ONE_MODE) begin
        mode_r[1] <= {w_r[7], 2'b00, w_r[4:0]};
      end
      if (wr_go && aw_r == `OFS_DATA_EP_TWO_MODE) begin
        mode_r[2] <= {w_r[7], 2'b00, w_r[4:0]};
      end
      if (setup_data) begin
        mode_r[0][`BIT_SETUP] <= 1'b1;
      end
      if (active_r && cur_ep_r == 2'd0 && cur_tok_r == TOK_SETUP && !hs_sent && !rx_done
          && mode_r[0][`BIT_SETUP]) begin
        mode_r[0][`BIT_SETUP] <= 1'b1;
      end
      if (ack_done) begin
        mode_r[cur_ep_r][`BIT_ACKED] <= 1'b1;
        if (cur_ep_r == 2'd0 && cur_tok_r == TOK_IN) begin
          mode_r[0][`BIT_IN] <= 1'b1;
        end
        if (cur_tok_r == TOK_OUT && mode_r[cur_ep_r][3:0] == `MODE_ACK_OUT_NAK_IN) begin
          mode_r[cur_ep_r][3:0] <= `MODE_NAK_INOUT;
        end
      end
      if (rx_end && rx_ok && cur_ep_r == 2'd0 && cur_tok_r == TOK_OUT) begin
        mode_r[0][`BIT_OUT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < 3; e++) begin
        cnt_r[e] <= `REG_RESET;
      end
    end else begin
      if (wr_go && aw_r == `OFS_CTRL_CNT && !cnt_lock_r) begin
        cnt_r[0] <= {w_r[7:6], 2'b00, w_r[3:0]};
      end
      if (wr_go && aw_r == `OFS_EP1_CNT) begin
        cnt_r[1] <= {w_r[7:6], 2'b00, w_r[3:0]};
      end
      if (wr_go && aw_r == `OFS_EP2_CNT) begin
        cnt_r[2] <= {w_r[7:6], 2'b00, w_r[3:0]};
      end
      if (rx_end && (hs_code == HS_ACK || !rx_ok)) begin
        cnt_r[cur_ep_r][`BIT_VALID] <= rx_ok;
        if (rx_ok) begin
          cnt_r[cur_ep_r][`BIT_TOGGLE] <= rx_toggle;
          cnt_r[cur_ep_r][3:0] <= rx_count + `CRC_BYTES;
        end
      end
    end
  end

endmodule : usb_endpoint_mode_count_regs

// file: tb/usb_ep_regs_sva.sv
// Concurrent checks on the endpoint register block ports
`timescale 1ns/10ps
module usb_ep_regs_chk
  import usb_ep_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_done,
  input wire logic rx_ok,
  input wire logic [1:0] hs_code,
  input wire logic hs_valid,
  input wire logic tx_valid,
  input wire logic tx_last
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_hs_pulse: assert property (hs_valid |-> hs_code != HS_NONE ##1 !hs_valid)
    else $error("handshake pulse malformed");
  chk_bad_noack: assert property (rx_done && !rx_ok |=> !(hs_valid && hs_code == HS_ACK))
    else $error("bad packet acknowledged");
  chk_last_valid: assert property (tx_last |-> tx_valid)
    else $error("last byte flag without data");

  cover property (hs_valid && hs_code == HS_STALL);
  cover property (hs_valid && hs_code == HS_ACK);
  cover property (tx_valid && tx_last);
endmodule : usb_ep_regs_chk

// file: tb/usb_host_model.sv
// Low-speed host stand-in driving the engine side of the block
`timescale 1ns/10ps
module usb_host_model
  import usb_ep_pkg::*;
(
  input wire logic aclk,
  output logic tok_valid,
  output logic [1:0] tok_kind,
  output logic [6:0] tok_addr,
  output logic [1:0] tok_ep,
  output logic data_start,
  output logic rx_done,
  output logic rx_ok,
  output logic rx_toggle,
  output logic [3:0] rx_count,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic hs_sent,
  output logic host_ack,
  output logic tx_ready,
  input wire logic [1:0] hs_code,
  input wire logic hs_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_toggle,
  input wire logic tx_last
);
  logic [1:0] last_hs;
  logic [7:0] got [0:15];
  int got_n;
  logic got_tg;

  initial begin
    {tok_valid, data_start, rx_done, rx_byte_valid, hs_sent, host_ack, tx_ready} = '0;
    {tok_kind, tok_addr, tok_ep, rx_ok, rx_toggle, rx_count, rx_byte} = '0;
    last_hs = HS_NONE;
  end

  // Handshake goes out on the wire one cycle after it is asked for
  always @(posedge aclk) begin
    hs_sent <= hs_valid;
    if (hs_valid)
      last_hs <= hs_code;
  end

  task automatic tok(input logic [1:0] k, input logic [6:0] a, input logic [1:0] e);
    last_hs = HS_NONE;
    tok_kind <= k;
    tok_addr <= a;
    tok_ep <= e;
    tok_valid <= 1'b1;
    @(posedge aclk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
  endtask : tok

  // Data packet with toggle of the host's choosing, at most eight bytes
  task automatic send_out(input logic tg, input int n, input logic ok, input logic [7:0] s);
    int i;
    data_start <= 1'b1;
    @(posedge aclk);
    data_start <= 1'b0;
    for (i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= s + 8'(i);
      @(posedge aclk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_done <= 1'b1;
    rx_ok <= ok;
    rx_toggle <= tg;
    rx_count <= 4'(n);
    @(posedge aclk);
    rx_done <= 1'b0;
    rx_ok <= ~ok;
    rx_toggle <= ~tg;
  endtask : send_out

  // Collect IN data with a stalling receiver, then acknowledge
  task automatic take_in();
    int i;
    int c;
    c = 0;
    got_n = -1;
    got_tg = 1'bx;
    for (i = 0; i < 200 && got_n < 0; i++) begin
      @(posedge aclk);
      if (tx_valid && tx_ready) begin
        got[c[3:0]] = tx_byte;
        c++;
        got_tg = tx_toggle;
        if (tx_last)
          got_n = 0;
      end
      tx_ready <= ~tx_ready;
    end
    tx_ready <= 1'b0;
    host_ack <= 1'b1;
    @(posedge aclk);
    host_ack <= 1'b0;
  endtask : take_in
endmodule : usb_host_model

// file: tb/test_usb_endpoint_mode_count_regs.sv
// Self-checking bench for the endpoint mode and counter registers
`timescale 1ns/10ps
`include "usb_ep_defines.svh"
module test_usb_endpoint_mode_count_regs
  import usb_ep_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, q, adr_e;
  logic [31:0] wdata, rnd;
  logic [1:0] r;
  logic [6:0] adr;
  wire awready, wready, bvalid, arready, rvalid, tok_valid, data_start, rx_done, rx_ok;
  wire rx_toggle, rx_byte_valid, hs_sent, host_ack, tx_ready, hs_valid, tx_valid;
  wire tx_toggle, tx_last;
  wire [1:0] bresp, rresp, tok_kind, tok_ep, hs_code;
  wire [31:0] rdata;
  wire [6:0] tok_addr;
  wire [3:0] rx_count;
  wire [7:0] rx_byte, tx_byte;
  wire [2:0] ep_event;
  int errors, check_count, evc, e0, i, n;

  always #4 aclk = ~aclk;
  always @(posedge aclk) if (ep_event[1]) evc++;

  usb_endpoint_mode_count_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_ep(tok_ep),
    .data_start(data_start), .rx_done(rx_done), .rx_ok(rx_ok), .rx_toggle(rx_toggle),
    .rx_count(rx_count), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .hs_sent(hs_sent), .host_ack(host_ack), .hs_code(hs_code), .hs_valid(hs_valid),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_toggle(tx_toggle), .tx_last(tx_last),
    .tx_ready(tx_ready), .ep_event(ep_event));

  usb_host_model host (.*);

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] fa(input logic [7:0] b, input int k);
    return 8'(`OFS_FIFO_WIN + 4 * (b - `FIFO_LO_BASE) + 4 * k);
  endfunction : fa

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    logic ah, wh, dn;
    dn = 1'b0;
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    for (k = 0; k < 64 && !dn; k++) begin
      @(negedge aclk);
      ah = w ? awvalid && awready : arvalid && arready;
      wh = wvalid && wready;
      dn = w ? bvalid : rvalid;
      q = rdata[7:0];
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (wh)
        wvalid <= 1'b0;
    end
    if (!dn) begin
      errors++;
      results();
    end
  endtask : bus

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    check(nm, q & m, e);
  endtask : rc

  task automatic wm(input logic [7:0] d);
    bus(1'b0, `OFS_CTRL_MODE, 8'h00);
    bus(1'b1, `OFS_CTRL_MODE, d);
  endtask : wm

  task automatic hs(input string nm, input logic [1:0] e);
    int k;
    for (k = 0; k < 8 && host.last_hs === HS_NONE; k++)
      @(posedge aclk);
    check(nm, {6'h0, host.last_hs}, {6'h0, e});
  endtask : hs

  task automatic in_run(input logic [1:0] e, input logic [7:0] fb, input logic [7:0] co);
    int k, m;
    logic [7:0] b;
    rnd = lfsr(rnd);
    m = 1 + int'(rnd[2:0]);
    b = rnd[15:8];
    for (k = 0; k < m; k++)
      bus(1'b1, fa(fb, k), b + 8'(k));
    bus(1'b1, co, {rnd[16], 3'h0, 4'(m)});
    host.tok(TOK_IN, adr, e);
    host.take_in();
    if (host.got_n < 0) begin
      errors++;
      results();
    end
    check("in toggle", {7'h0, host.got_tg}, {7'h0, rnd[16]});
    for (k = 0; k < m; k++)
      check("in byte", host.got[k], b + 8'(k));
  endtask : in_run

  // ----
  // Main sequence
  // ----
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    {errors, check_count, evc} = '0;
    rnd = 32'h4fa6806e;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 6; i++)
      rc("reset value", 8'(`OFS_CTRL_CNT + 4 * i), 8'h00, 8'hff);
    rc("unmapped", 8'h7c, 8'h00, 8'hff);
    check("unmapped resp", {6'h0, r}, 8'h02);
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      adr_e = i[0] ? `OFS_DATA_EP_TWO_MODE : `OFS_DATA_EP_ONE_MODE;
      bus(1'b1, adr_e, rnd[7:0] & 8'h9f);
      rc("data mode", adr_e, rnd[7:0] & 8'h9f, 8'hff);
    end
    $display("test registers done");
    adr = {rnd[14:9], 1'b1};
    wm(8'h01);
    host.tok(TOK_IN, adr, 2'd0);
    hs("disabled addr", HS_NONE);
    bus(1'b1, `OFS_DEV_ADDR, {1'b1, adr});
    host.tok(TOK_IN, adr ^ 7'h04, 2'd0);
    hs("other addr", HS_NONE);
    host.tok(TOK_IN, adr, 2'd0);
    hs("nak in", HS_NAK);
    host.tok(TOK_OUT, adr, 2'd0);
    host.send_out(1'b0, 2, 1'b1, 8'h11);
    hs("nak out", HS_NAK);
    wm(8'h01);
    host.tok(TOK_SETUP, adr, 2'd0);
    host.send_out(1'b0, 8, 1'b1, 8'h50);
    hs("ack setup", HS_ACK);
    bus(1'b1, `OFS_CTRL_MODE, 8'h0b);
    bus(1'b1, `OFS_CTRL_CNT, 8'h05);
    bus(1'b1, fa(`FIFO_CTRL_BASE, 0), 8'hee);
    rc("mode locked", `OFS_CTRL_MODE, 8'h91, 8'hff);
    rc("cnt setup", `OFS_CTRL_CNT, 8'h4a, 8'hcf);
    rc("fifo kept", fa(`FIFO_CTRL_BASE, 0), 8'h50, 8'hff);
    wm(8'h0b);
    rc("flags cleared", `OFS_CTRL_MODE, 8'h0b, 8'hff);
    bus(1'b1, fa(`FIFO_CTRL_BASE, 0), 8'hee);
    rc("fifo free", fa(`FIFO_CTRL_BASE, 0), 8'hee, 8'hff);
    $display("test setup done");
    for (i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      n = int'(rnd[3:0]) % 9;
      wm(8'h0b);
      host.tok(TOK_OUT, adr, 2'd0);
      host.send_out(rnd[4], n, 1'b1, rnd[15:8]);
      hs("ack out", HS_ACK);
      rc("mode auto", `OFS_CTRL_MODE, 8'h31, 8'hff);
      rc("cnt out", `OFS_CTRL_CNT, {rnd[4], 3'h4, 4'(n + 2)}, 8'hcf);
    end
    $display("test out done");
    wm(8'h0f);
    in_run(2'd0, `FIFO_CTRL_BASE, `OFS_CTRL_CNT);
    rc("in flag", `OFS_CTRL_MODE, 8'h5f, 8'hff);
    bus(1'b1, `OFS_DATA_EP_TWO_MODE, 8'h0f);
    in_run(2'd2, `FIFO_EP2_BASE, `OFS_EP2_CNT);
    rc("ep2 acked", `OFS_DATA_EP_TWO_MODE, 8'h1f, 8'hff);
    $display("test in done");
    bus(1'b1, `OFS_DATA_EP_TWO_MODE, 8'h8f);
    host.tok(TOK_IN, adr, 2'd2);
    hs("stall in", HS_STALL);
    bus(1'b1, `OFS_DATA_EP_ONE_MODE, 8'h89);
    host.tok(TOK_OUT, adr, 2'd1);
    host.send_out(1'b1, 3, 1'b1, 8'h20);
    hs("stall out", HS_STALL);
    bus(1'b1, `OFS_DATA_EP_ONE_MODE, 8'h09);
    e0 = evc;
    host.tok(TOK_OUT, adr, 2'd1);
    host.send_out(1'b1, 4, 1'b0, 8'h30);
    hs("bad data", HS_NONE);
    check("bad event", 8'(evc > e0), 8'h01);
    rc("bad valid", `OFS_EP1_CNT, 8'h00, 8'h40);
    host.tok(TOK_OUT, adr, 2'd1);
    host.send_out(1'b1, 5, 1'b1, 8'h40);
    hs("ep1 ack", HS_ACK);
    rc("ep1 cnt", `OFS_EP1_CNT, 8'hc7, 8'hcf);
    rc("ep1 acked", `OFS_DATA_EP_ONE_MODE, 8'h10, 8'h10);
    $display("test data endpoints done");
    results();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    results();
  end
endmodule : test_usb_endpoint_mode_count_regs

bind usb_endpoint_mode_count_regs usb_ep_regs_chk chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .rx_done(rx_done), .rx_ok(rx_ok), .hs_code(hs_code),
  .hs_valid(hs_valid), .tx_valid(tx_valid), .tx_last(tx_last));
